/* src/pmc_pkg.sv */
// Summary of operation
// - In normal mode the core runs and every enabled peripheral clock is on.
// - Setting the idle request bit halts the core, peripherals stay clocked, any interrupt wakes.
// - A wake from idle, suspend or sleep releases the core halt without any reset.
// - Suspend needs the fast or low-power oscillator selected, then halts core and peripherals and stops the oscillators.
// - Setting the stop request bit shuts all internal power nets while pins hold state.
// - Stop mode is left only through reset, and any reset source does it.
// - Sleep shuts most power nets and wakes on counter alarm, counter fail, port match or comparator-0 rising edge.
// - During sleep retention power stays on so RAM, registers and pins keep their state.
// - A digital peripheral clock is gated off while that peripheral is not in use.
// - After reset the system clock runs from the low-power oscillator divided by eight.
// - The clock divider divides the selected source by any power of two from 1 to 128.
// - Every analog peripheral has its own disable control.
package pmc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
	localparam logic [7:0] OFS_POWER_UNIT_CONFIG = 8'h04;
	localparam logic [7:0] OFS_CLOCK_CTRL = 8'h08;
	localparam logic [7:0] OFS_PERIPH_CLK_EN = 8'h0C;
	localparam logic [7:0] OFS_ANALOG_DIS = 8'h10;
	localparam logic [7:0] OFS_MODE_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	// field positions
	localparam int BIT_IDLE = 0;
	localparam int BIT_STOP = 1;
	localparam int BIT_SLEEP = 0;
	localparam int BIT_SUSPEND = 1;
	localparam int POS_CLK_SRC = 0;
	localparam int POS_CLK_DIV = 4;
	localparam int IRQ_IDLE_WAKE = 0;
	localparam int IRQ_SUSPEND_WAKE = 1;
	localparam int IRQ_SLEEP_WAKE = 2;
	localparam int IRQ_REFUSED = 3;
	// widths
	localparam int NUM_DIG_PERIPH = 8;
	localparam int NUM_ANALOG = 4;
	localparam int NUM_WAKE = 4;
	localparam int NUM_IRQ = 4;
	// clock source codes
	localparam logic [1:0] SRC_FAST = 2'h0;
	localparam logic [1:0] SRC_LOW_POWER = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h2;
	// reset values
	localparam logic [1:0] RST_CLK_SRC = SRC_LOW_POWER;
	localparam logic [2:0] RST_CLK_DIV = 3'h3;
	localparam logic [NUM_DIG_PERIPH-1:0] RST_PERIPH_EN = 8'hFF;
	localparam logic [NUM_ANALOG-1:0] RST_ANALOG_DIS = 4'h0;
	localparam logic [NUM_IRQ-1:0] RST_IRQ_MASK = 4'h0;
	// wake inputs: alarm, fail, port match, comparator 0; edge-qualified ones marked
	localparam logic [NUM_WAKE-1:0] WAKE_EDGE_MASK = 4'h8;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_IDLE,
		MODE_SUSPEND,
		MODE_STOP,
		MODE_SLEEP
	} pmc_mode_e;
endpackage

/* src/pmc_clk_div.sv */
`timescale 1ns/1ps
module pmc_clk_div
	import pmc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// control
	input wire logic [2:0] div_sel,
	// divided clock tick
	output logic tick
);
	logic [6:0] cnt_reg;
	logic [7:0] mask_wide;
	logic [6:0] mask;
	logic hit;

	always_comb begin
		mask_wide = (8'h01 << div_sel) - 8'h01;
		mask = mask_wide[6:0];
		hit = &(cnt_reg | ~mask);
	end

	// one tick every 2**div_sel source cycles
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 7'h00;
		end else if (hit) begin
			cnt_reg <= 7'h00;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick <= 1'b0;
		end else begin
			tick <= hit;
		end
	end
endmodule

/* src/pmc_wake_det.sv */
`timescale 1ns/1ps
module pmc_wake_det
	import pmc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// raw wake sources
	input wire logic [NUM_WAKE-1:0] src,
	// qualified wake hits, one cycle late
	output logic [NUM_WAKE-1:0] hit
);
	logic [NUM_WAKE-1:0] prev_reg;

	// comparator only counts on its rising edge, the rest as levels
	for (genvar i = 0; i < NUM_WAKE; i++) begin : g_src
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				prev_reg[i] <= 1'b0;
				hit[i] <= 1'b0;
			end else begin
				prev_reg[i] <= src[i];
				hit[i] <= WAKE_EDGE_MASK[i] ? (src[i] & ~prev_reg[i]) : src[i];
			end
		end
	end
endmodule

/* src/pmc_top.sv */
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module pmc_top
	import pmc_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// AXI4-Lite write address
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// wake sources
	input wire logic INT_PENDING,
	input wire logic COUNTER_ALARM,
	input wire logic COUNTER_FAIL,
	input wire logic PORT_MATCH,
	input wire logic CMP0_OUT,
	// power and clock controls
	output logic CORE_HALT,
	output logic [NUM_DIG_PERIPH-1:0] PERIPH_CLK_EN,
	output logic FAST_OSC_EN,
	output logic LOW_POWER_OSC_EN,
	output logic POWER_NET_EN,
	output logic RETAIN_EN,
	output logic PIN_HOLD,
	output logic [NUM_ANALOG-1:0] ANALOG_DIS,
	output logic [1:0] SYSTEM_CLOCK_SRC,
	output logic SYSTEM_CLOCK_TICK,
	// interrupt
	output logic IRQ
);
	pmc_mode_e state_reg, state_next;
	logic idle_req_reg, stop_req_reg, sleep_req_reg, suspend_req_reg;
	logic [1:0] clk_src_reg;
	logic [2:0] clk_div_reg;
	logic [NUM_DIG_PERIPH-1:0] periph_en_reg;
	logic [NUM_ANALOG-1:0] analog_dis_reg;
	logic [NUM_IRQ-1:0] irq_stat_reg, irq_mask_reg, irq_set, irq_clr;
	logic aw_full_reg, w_full_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write, byte0_we;
	logic [31:0] rdata_next;
	logic rd_ok, rd_take;
	logic [NUM_WAKE-1:0] wake_hit;
	logic any_wake, idle_wake;
	logic wr_idle, wr_stop, wr_sleep, wr_suspend, refuse_suspend;
	logic clr_idle, clr_sleep, clr_suspend;

	// ---------------- AXI write channel ----------------
	assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_full_reg && !S_AXI_BVALID;
	assign do_write = aw_full_reg && w_full_reg && !S_AXI_BVALID;
	// only the low byte holds fields, so only its strobe matters
	assign byte0_we = do_write && wstrb_reg[0];

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			aw_full_reg <= 1'b0;
			awaddr_reg <= 8'h00;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_full_reg <= 1'b1;
			awaddr_reg <= S_AXI_AWADDR;
		end else if (do_write) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			w_full_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_full_reg <= 1'b1;
			wdata_reg <= S_AXI_WDATA;
			wstrb_reg <= S_AXI_WSTRB;
		end else if (do_write) begin
			w_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			if (awaddr_reg == OFS_POWER_CONTROL || awaddr_reg == OFS_POWER_UNIT_CONFIG ||
				awaddr_reg == OFS_CLOCK_CTRL || awaddr_reg == OFS_PERIPH_CLK_EN ||
				awaddr_reg == OFS_ANALOG_DIS || awaddr_reg == OFS_IRQ_MASK) begin
				S_AXI_BRESP <= RESP_OKAY;
			end else begin
				S_AXI_BRESP <= RESP_SLVERR;
			end
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// ---------------- request decode ----------------
	assign wr_idle = byte0_we && awaddr_reg == OFS_POWER_CONTROL && wdata_reg[BIT_IDLE];
	assign wr_stop = byte0_we && awaddr_reg == OFS_POWER_CONTROL && wdata_reg[BIT_STOP];
	assign wr_sleep = byte0_we && awaddr_reg == OFS_POWER_UNIT_CONFIG && wdata_reg[BIT_SLEEP];
	// suspend from an external clock would never wake, so it is refused
	assign refuse_suspend = byte0_we && awaddr_reg == OFS_POWER_UNIT_CONFIG &&
		wdata_reg[BIT_SUSPEND] && clk_src_reg != SRC_FAST && clk_src_reg != SRC_LOW_POWER;
	assign wr_suspend = byte0_we && awaddr_reg == OFS_POWER_UNIT_CONFIG &&
		wdata_reg[BIT_SUSPEND] && !refuse_suspend;

	// ---------------- wake qualification ----------------
	pmc_wake_det u_wake (
		.clk(CLK),
		.resetn(RESETN),
		.src({CMP0_OUT, PORT_MATCH, COUNTER_FAIL, COUNTER_ALARM}),
		.hit(wake_hit)
	);

	assign any_wake = |wake_hit;
	assign idle_wake = INT_PENDING || IRQ;
	assign clr_idle = state_reg == MODE_IDLE && idle_wake;
	assign clr_suspend = state_reg == MODE_SUSPEND && any_wake;
	assign clr_sleep = state_reg == MODE_SLEEP && any_wake;

	// ---------------- request bits, set wins over clear ----------------
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			idle_req_reg <= 1'b0;
			suspend_req_reg <= 1'b0;
			sleep_req_reg <= 1'b0;
		end else begin
			idle_req_reg <= (idle_req_reg && !clr_idle) || wr_idle;
			suspend_req_reg <= (suspend_req_reg && !clr_suspend) || wr_suspend;
			sleep_req_reg <= (sleep_req_reg && !clr_sleep) || wr_sleep;
		end
	end

	// stop is cleared by nothing but reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			stop_req_reg <= 1'b0;
		end else if (wr_stop) begin
			stop_req_reg <= 1'b1;
		end
	end

	// ---------------- configuration registers ----------------
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			clk_src_reg <= RST_CLK_SRC;
			clk_div_reg <= RST_CLK_DIV;
		end else if (byte0_we && awaddr_reg == OFS_CLOCK_CTRL) begin
			clk_src_reg <= wdata_reg[POS_CLK_SRC +: 2];
			clk_div_reg <= wdata_reg[POS_CLK_DIV +: 3];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			periph_en_reg <= RST_PERIPH_EN;
		end else if (byte0_we && awaddr_reg == OFS_PERIPH_CLK_EN) begin
			periph_en_reg <= wdata_reg[NUM_DIG_PERIPH-1:0];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			analog_dis_reg <= RST_ANALOG_DIS;
		end else if (byte0_we && awaddr_reg == OFS_ANALOG_DIS) begin
			analog_dis_reg <= wdata_reg[NUM_ANALOG-1:0];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_mask_reg <= RST_IRQ_MASK;
		end else if (byte0_we && awaddr_reg == OFS_IRQ_MASK) begin
			irq_mask_reg <= wdata_reg[NUM_IRQ-1:0];
		end
	end

	// ---------------- mode state machine ----------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MODE_NORMAL: begin
				// stop outranks sleep, sleep outranks suspend, suspend outranks idle
				if (stop_req_reg) begin
					state_next = MODE_STOP;
				end else if (sleep_req_reg) begin
					state_next = MODE_SLEEP;
				end else if (suspend_req_reg) begin
					state_next = MODE_SUSPEND;
				end else if (idle_req_reg) begin
					state_next = MODE_IDLE;
				end
			end
			MODE_IDLE: begin
				if (idle_wake) begin
					state_next = MODE_NORMAL;
				end
			end
			MODE_SUSPEND, MODE_SLEEP: begin
				if (any_wake) begin
					state_next = MODE_NORMAL;
				end
			end
			MODE_STOP: begin
				state_next = MODE_STOP;
			end
			default: begin
				state_next = MODE_NORMAL;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= MODE_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// ---------------- power and clock outputs ----------------
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			CORE_HALT <= 1'b0;
			PERIPH_CLK_EN <= RST_PERIPH_EN;
			FAST_OSC_EN <= 1'b0;
			LOW_POWER_OSC_EN <= 1'b1;
			POWER_NET_EN <= 1'b1;
			RETAIN_EN <= 1'b0;
			PIN_HOLD <= 1'b0;
		end else begin
			// the core resumes by dropping halt, no reset involved
			CORE_HALT <= state_next != MODE_NORMAL;
			if (state_next == MODE_NORMAL || state_next == MODE_IDLE) begin
				PERIPH_CLK_EN <= periph_en_reg;
				FAST_OSC_EN <= clk_src_reg == SRC_FAST;
				LOW_POWER_OSC_EN <= clk_src_reg == SRC_LOW_POWER;
			end else begin
				PERIPH_CLK_EN <= '0;
				FAST_OSC_EN <= 1'b0;
				LOW_POWER_OSC_EN <= 1'b0;
			end
			POWER_NET_EN <= state_next != MODE_STOP && state_next != MODE_SLEEP;
			RETAIN_EN <= state_next == MODE_SLEEP;
			PIN_HOLD <= state_next == MODE_STOP || state_next == MODE_SLEEP;
		end
	end

	assign ANALOG_DIS = analog_dis_reg;
	assign SYSTEM_CLOCK_SRC = clk_src_reg;

	pmc_clk_div u_div (
		.clk(CLK),
		.resetn(RESETN),
		.div_sel(clk_div_reg),
		.tick(SYSTEM_CLOCK_TICK)
	);

	// ---------------- interrupts ----------------
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_IDLE_WAKE] = clr_idle;
		irq_set[IRQ_SUSPEND_WAKE] = clr_suspend;
		irq_set[IRQ_SLEEP_WAKE] = clr_sleep;
		irq_set[IRQ_REFUSED] = refuse_suspend;
	end

	assign irq_clr = (rd_take && S_AXI_ARADDR == OFS_IRQ_STATUS) ? '1 : '0;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
		end
	end

	// idle wake already includes IRQ, so a wake event in idle can not loop back
	assign IRQ = |(irq_stat_reg & irq_mask_reg);

	// ---------------- AXI read channel ----------------
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;

	always_comb begin
		rdata_next = 32'h0000_0000;
		rd_ok = 1'b1;
		if (S_AXI_ARADDR == OFS_POWER_CONTROL) begin
			rdata_next[BIT_IDLE] = idle_req_reg;
			rdata_next[BIT_STOP] = stop_req_reg;
		end else if (S_AXI_ARADDR == OFS_POWER_UNIT_CONFIG) begin
			rdata_next[BIT_SLEEP] = sleep_req_reg;
			rdata_next[BIT_SUSPEND] = suspend_req_reg;
		end else if (S_AXI_ARADDR == OFS_CLOCK_CTRL) begin
			rdata_next[POS_CLK_SRC +: 2] = clk_src_reg;
			rdata_next[POS_CLK_DIV +: 3] = clk_div_reg;
		end else if (S_AXI_ARADDR == OFS_PERIPH_CLK_EN) begin
			rdata_next[NUM_DIG_PERIPH-1:0] = periph_en_reg;
		end else if (S_AXI_ARADDR == OFS_ANALOG_DIS) begin
			rdata_next[NUM_ANALOG-1:0] = analog_dis_reg;
		end else if (S_AXI_ARADDR == OFS_MODE_STATUS) begin
			rdata_next[2:0] = state_reg;
		end else if (S_AXI_ARADDR == OFS_IRQ_STATUS) begin
			rdata_next[NUM_IRQ-1:0] = irq_stat_reg;
		end else if (S_AXI_ARADDR == OFS_IRQ_MASK) begin
			rdata_next[NUM_IRQ-1:0] = irq_mask_reg;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (rd_take) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rdata_next;
			S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule

/* testbench/pmc_wake_model.sv */
`timescale 1ns/1ps
module pmc_wake_model (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// core state and bench command
	input wire logic core_halt,
	input wire logic go,
	input wire logic [2:0] sel,
	input wire logic [2:0] lag,
	// wake lines
	output logic int_pending,
	output logic counter_alarm,
	output logic counter_fail,
	output logic port_match,
	output logic cmp0_out
);
	logic [2:0] sel_reg;
	logic [2:0] cnt_reg;
	logic act_reg;
	logic on;
	// source holds until the core runs again; lag models a slow source
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			act_reg <= 1'b0;
			cnt_reg <= 3'h0;
			sel_reg <= 3'h0;
		end else if (go) begin
			act_reg <= 1'b1;
			cnt_reg <= lag;
			sel_reg <= sel;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end else if (!core_halt) begin
			act_reg <= 1'b0;
		end
	end
	assign on = act_reg && cnt_reg == 3'h0;
	assign int_pending = on && sel_reg == 3'h1;
	assign counter_alarm = on && sel_reg == 3'h2;
	assign counter_fail = on && sel_reg == 3'h3;
	assign port_match = on && sel_reg == 3'h4;
	assign cmp0_out = on && sel_reg == 3'h5; // low until fired, so one rising edge
endmodule

/* testbench/pmc_top_asserts.sv */
`timescale 1ns/1ps
module pmc_top_asserts
	import pmc_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// wake sources
	input wire logic INT_PENDING,
	input wire logic COUNTER_ALARM,
	input wire logic COUNTER_FAIL,
	input wire logic PORT_MATCH,
	input wire logic CMP0_OUT,
	// power and clock controls
	input wire logic CORE_HALT,
	input wire logic [NUM_DIG_PERIPH-1:0] PERIPH_CLK_EN,
	input wire logic FAST_OSC_EN,
	input wire logic LOW_POWER_OSC_EN,
	input wire logic POWER_NET_EN,
	input wire logic RETAIN_EN,
	input wire logic PIN_HOLD,
	input wire logic [1:0] SYSTEM_CLOCK_SRC,
	input wire logic IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	sequence s_idle; CORE_HALT && (FAST_OSC_EN || LOW_POWER_OSC_EN); endsequence
	// external source never enters suspend, so this tells suspend from idle
	sequence s_susp;
		CORE_HALT && POWER_NET_EN && !FAST_OSC_EN && !LOW_POWER_OSC_EN
			&& SYSTEM_CLOCK_SRC < SRC_EXTERNAL;
	endsequence
	sequence s_sleep; CORE_HALT && RETAIN_EN; endsequence
	sequence s_stop; CORE_HALT && !POWER_NET_EN && !RETAIN_EN; endsequence
	sequence s_wake; COUNTER_ALARM || COUNTER_FAIL || PORT_MATCH || $rose(CMP0_OUT); endsequence
	property p_normal; !CORE_HALT |-> POWER_NET_EN && !PIN_HOLD && !RETAIN_EN; endproperty
	a_normal: assert property (p_normal) else $error("running core lacks power");
	property p_idle_wake; s_idle ##0 (INT_PENDING || IRQ) |=> !CORE_HALT; endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle not woken");
	property p_susp_gate; s_susp |-> PERIPH_CLK_EN == '0; endproperty
	a_susp_gate: assert property (p_susp_gate) else $error("clocks on in suspend");
	property p_susp_wake; s_susp ##0 s_wake |-> ##2 !CORE_HALT; endproperty
	a_susp_wake: assert property (p_susp_wake) else $error("suspend not woken");
	property p_sleep_wake; s_sleep ##0 s_wake |-> ##2 !CORE_HALT; endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not woken");
	property p_stop_hold; s_stop |=> s_stop; endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");
	property p_stop_pins;
		PIN_HOLD && !RETAIN_EN |-> CORE_HALT && !POWER_NET_EN && !FAST_OSC_EN
			&& !LOW_POWER_OSC_EN && PERIPH_CLK_EN == '0;
	endproperty
	a_stop_pins: assert property (p_stop_pins) else $error("stop not fully off");
	property p_sleep_keep; RETAIN_EN |-> PIN_HOLD && !POWER_NET_EN && CORE_HALT; endproperty
	a_sleep_keep: assert property (p_sleep_keep) else $error("sleep state lost");
	property p_reset_clk;
		$rose(RESETN) |-> SYSTEM_CLOCK_SRC == RST_CLK_SRC && LOW_POWER_OSC_EN
			&& !FAST_OSC_EN && !CORE_HALT;
	endproperty
	a_reset_clk: assert property (p_reset_clk) else $error("bad clock after reset");
endmodule
bind pmc_top pmc_top_asserts i_asserts (.CLK(CLK), .RESETN(RESETN), .INT_PENDING(INT_PENDING),
	.COUNTER_ALARM(COUNTER_ALARM), .COUNTER_FAIL(COUNTER_FAIL), .PORT_MATCH(PORT_MATCH),
	.CMP0_OUT(CMP0_OUT), .CORE_HALT(CORE_HALT), .PERIPH_CLK_EN(PERIPH_CLK_EN),
	.FAST_OSC_EN(FAST_OSC_EN), .LOW_POWER_OSC_EN(LOW_POWER_OSC_EN),
	.POWER_NET_EN(POWER_NET_EN), .RETAIN_EN(RETAIN_EN), .PIN_HOLD(PIN_HOLD),
	.SYSTEM_CLOCK_SRC(SYSTEM_CLOCK_SRC), .IRQ(IRQ));

/* testbench/test_power_mode_controller.sv */
`timescale 1ns/1ps
module test_power_mode_controller;
	import pmc_pkg::*;
	logic clk, rstn, awv, wv, br, arv, rr, awr, wr, bv, arr, rv, go;
	logic ip, al, fl, pm, cm, halt, fosc, losc, pnet, ret, hold, tick, irq;
	logic [7:0] awa, ara, pclk, pe;
	logic [31:0] wd, rdat, v;
	logic [3:0] ws, adis, ad, mk;
	logic [1:0] bresp, rresp, src, r, cs;
	logic [2:0] wsel, lag;
	int miscompares, total_checks, n, k;
	pmc_top i_dut (.CLK(clk), .RESETN(rstn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .INT_PENDING(ip),
		.COUNTER_ALARM(al), .COUNTER_FAIL(fl), .PORT_MATCH(pm), .CMP0_OUT(cm),
		.CORE_HALT(halt), .PERIPH_CLK_EN(pclk), .FAST_OSC_EN(fosc), .LOW_POWER_OSC_EN(losc),
		.POWER_NET_EN(pnet), .RETAIN_EN(ret), .PIN_HOLD(hold), .ANALOG_DIS(adis),
		.SYSTEM_CLOCK_SRC(src), .SYSTEM_CLOCK_TICK(tick), .IRQ(irq));
	pmc_wake_model i_wake (.clk(clk), .resetn(rstn), .core_halt(halt), .go(go), .sel(wsel),
		.lag(lag), .int_pending(ip), .counter_alarm(al), .counter_fail(fl), .port_match(pm),
		.cmp0_out(cm));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [31:0] ccv(input logic [1:0] s, input logic [2:0] d);
		return {25'h0, d, 2'h0, s};
	endfunction
	function automatic logic [31:0] rst_val(input int i);
		return i == 2 ? ccv(RST_CLK_SRC, RST_CLK_DIV) : i == 3 ? 32'(RST_PERIPH_EN) :
			i == 4 ? 32'(RST_ANALOG_DIS) : i == 7 ? 32'(RST_IRQ_MASK) : 32'h0;
	endfunction
	// {fast osc, low-power osc, retain, pin hold} while halted in idle, suspend or sleep
	function automatic logic [3:0] osc_exp(input int m, input logic [1:0] s);
		return m == 0 ? {s == SRC_FAST, s == SRC_LOW_POWER, 2'b00} : {2'b00, m == 2, m == 2};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task conclude;
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// readies are taken at the negedge: they settle there and hold until the edge
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wr;
			tb = bv;
			r = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tb);
		br <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		logic ta, tb;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(negedge clk);
			ta = arv && arr;
			tb = rv;
			v = rdat;
			r = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end while (!tb);
		rr <= 1'b0;
		chk(v, e);
	endtask
	task fire(input logic [2:0] s);
		wsel <= s;
		lag <= 3'($urandom);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	initial begin
		{awa, ara, wd, awv, wv, br, arv, rr, go, wsel, lag} = '0;
		ws = 4'hF;
		miscompares = 0;
		total_checks = 0;
		rstn = 1'b0;
		v = $urandom(36);
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rchk(8'(4 * i), rst_val(i));
			chk(r, i < 8 ? RESP_OKAY : RESP_SLVERR);
		end
		chk(src, RST_CLK_SRC);
		axw(OFS_MODE_STATUS, 32'h1);
		chk(r, RESP_SLVERR);
		// skip the first gap: the divider may be mid-count when changed
		for (int d = 0; d < 8; d++) begin
			axw(OFS_CLOCK_CTRL, ccv(SRC_LOW_POWER, 3'(d)));
			for (int j = 0; j < 2; j++) begin
				n = 0;
				do begin
					@(negedge clk);
					n++;
				end while (tick !== 1'b1 && n < 300);
			end
			chk(n, 1 << d);
		end
		repeat (4) begin
			pe = 8'($urandom);
			ad = 4'($urandom);
			axw(OFS_PERIPH_CLK_EN, 32'(pe));
			axw(OFS_ANALOG_DIS, 32'(ad));
			chk(pclk, pe);
			chk(adis, ad);
		end
		for (int i = 0; i < 5; i++) begin
			k = i == 0 ? 0 : i < 3 ? 1 : 2;
			mk = 4'($urandom);
			axw(OFS_IRQ_MASK, 32'(mk));
			cs = 2'($urandom_range(1, 0));
			axw(OFS_CLOCK_CTRL, ccv(cs, 3'h3));
			axw(k == 0 ? OFS_POWER_CONTROL : OFS_POWER_UNIT_CONFIG,
				1 << (k == 0 ? BIT_IDLE : k == 1 ? BIT_SUSPEND : BIT_SLEEP));
			// mode outputs move on the edge the write returns on, so let them settle
			@(negedge clk);
			chk(halt, 1'b1);
			chk(pclk, k == 0 ? pe : 8'h0);
			chk({fosc, losc, ret, hold}, osc_exp(k, cs));
			rchk(OFS_MODE_STATUS, 32'(k == 0 ? MODE_IDLE : k == 1 ? MODE_SUSPEND : MODE_SLEEP));
			rchk(OFS_PERIPH_CLK_EN, 32'(pe));
			fire(3'(i + 1));
			n = 0;
			while (halt !== 1'b0 && n < 40) begin
				@(negedge clk);
				n++;
			end
			chk(halt, 1'b0);
			rchk(k == 0 ? OFS_POWER_CONTROL : OFS_POWER_UNIT_CONFIG, 32'h0);
			chk(irq, mk[k]);
			rchk(OFS_IRQ_STATUS, 1 << k);
			chk(irq, 1'b0);
		end
		axw(OFS_IRQ_MASK, 32'h8);
		axw(OFS_CLOCK_CTRL, ccv(SRC_EXTERNAL, 3'h3));
		axw(OFS_POWER_UNIT_CONFIG, 1 << BIT_SUSPEND);
		rchk(OFS_POWER_UNIT_CONFIG, 32'h0);
		chk(halt, 1'b0);
		chk(irq, 1'b1);
		rchk(OFS_IRQ_STATUS, 1 << IRQ_REFUSED);
		axw(OFS_POWER_CONTROL, 1 << BIT_STOP);
		fire(3'h2);
		repeat (50) @(negedge clk);
		chk({halt, hold, pnet}, 3'b110);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk(halt, 1'b0);
		chk({fosc, losc}, 2'b01);
		rchk(OFS_CLOCK_CTRL, rst_val(2));
		conclude;
	end
	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		conclude;
	end
endmodule
